// ---- afrc_pkg.sv ----
// Constants, types and register map of the amplifier fault report combiner.
// Assumes one 250 MHz clock and a synchronous active-low reset in every user.
package afrc_pkg;

   // ----------------------------------------------------------------------
   // Stage layout
   // ----------------------------------------------------------------------
   localparam int NUM_STAGES = 8;
   // Stage order: FL, FR, RL, RR, SL, SR, C, SUB; a set bit marks primary.
   localparam logic [7:0] PRIMARY_GROUP = 8'h43;

   // ----------------------------------------------------------------------
   // Register map, byte addresses
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RAW = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0c;
   localparam logic [7:0] ADDR_COND = 8'h10;

   // Control fields.
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_REPORT_EN = 3;
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [7:0] MASK_RESET = 8'h00;

   // Status event bit positions, mask uses the same layout.
   localparam int EV_PRIMARY = 0;
   localparam int EV_SECONDARY = 1;
   localparam int EV_OVERTEMP = 2;
   localparam int EV_BITS = 3;

   // Raw field positions.
   localparam int RAW_SD_LSB = 0;
   localparam int RAW_OTW_LSB = 8;
   localparam int RAW_LINE_LSB = 16;

   // Bus answers.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Device condition seen on a warning and shutdown pair.
   typedef enum logic [1:0] {
      AFRC_COND_NORMAL = 2'h0,
      AFRC_COND_TEMP_WARN = 2'h1,
      AFRC_COND_UVLO_CURRENT = 2'h3,
      AFRC_COND_HOT_ERROR = 2'h2
   } afrc_cond_e;

   // Register write request from the bus slave.
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } afrc_wreq_s;

   // One open-drain pin as seen from the design.
   typedef struct packed {
      logic out;
      logic oe_n;
   } afrc_od_s;

endpackage

// ---- afrc_sync.sv ----
// Two flip-flop synchroniser for a vector of unrelated levels.
// Assumes each bit is a slow level from a pin; no bus coherence is offered.
`timescale 1ns/100ps
module afrc_sync import afrc_pkg::*; #(
   parameter int WIDTH = 8,
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   // ----------------------------------------------------------------------
   // Per-bit stages
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_ff;
         logic sync_ff;
         // The first stage feeds only the second, so metastability settles there.
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta_ff <= RESET_VAL;
               sync_ff <= RESET_VAL;
            end else begin
               meta_ff <= d[i];
               sync_ff <= meta_ff;
            end
         end
         assign q[i] = sync_ff;
      end
   endgenerate

endmodule

// ---- afrc_axil.sv ----
// AXI4-Lite slave front end: takes address and data in either order.
// Assumes the register file answers combinationally on decode and error.
`timescale 1ns/100ps
module afrc_axil import afrc_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output afrc_wreq_s wr_req,
   input wire logic wr_ok,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);

   logic awready_ff, wready_ff, bvalid_ff, aw_full_ff, w_full_ff;
   logic arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   afrc_wreq_s req_ff;

   // ----------------------------------------------------------------------
   // Write path
   // ----------------------------------------------------------------------
   // The write fires once both halves are held and no answer is pending.
   assign wr_en = aw_full_ff && w_full_ff && !bvalid_ff;
   assign wr_req = req_ff;

   // Each half is held until the pair is committed; one write at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         aw_full_ff <= 1'b0;
         w_full_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
         req_ff <= '0;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            aw_full_ff <= 1'b1;
            awready_ff <= 1'b0;
            req_ff.addr <= s_axi_awaddr;
         end else if (!aw_full_ff && !bvalid_ff) begin
            awready_ff <= 1'b1;
         end
         if (s_axi_wvalid && wready_ff) begin
            w_full_ff <= 1'b1;
            wready_ff <= 1'b0;
            req_ff.data <= s_axi_wdata;
            req_ff.strb <= s_axi_wstrb;
         end else if (!w_full_ff && !bvalid_ff) begin
            wready_ff <= 1'b1;
         end
         if (wr_en) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // Data is captured at the address handshake; reads have no side effect.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_ok ? rd_data : 32'h0;
         rresp_ff <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end else if (!rvalid_ff) begin
         arready_ff <= 1'b1;
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;

endmodule

// ---- afrc_top.sv ----
// Fault report combiner for eight power output stages, with register access.
// Assumes stage report pins are asynchronous active-low levels, the three
// combined lines are open drain with an outside pull-up, and a supervisor
// reads the lines and the registers over AXI4-Lite.
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
module afrc_top import afrc_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_STAGES-1:0] stage_shutdown_n,
   input wire logic [NUM_STAGES-1:0] stage_overtemp_n,
   output logic mode_select_pin_a,
   output logic mode_select_pin_b,
   output logic mode_select_pin_c,
   input wire logic primary_shutdown_n_in,
   output logic primary_shutdown_n_out,
   output logic primary_shutdown_n_oe_n,
   input wire logic secondary_shutdown_n_in,
   output logic secondary_shutdown_n_out,
   output logic secondary_shutdown_n_oe_n,
   input wire logic overtemp_warning_n_in,
   output logic overtemp_warning_n_out,
   output logic overtemp_warning_n_oe_n,
   output logic irq
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [NUM_STAGES-1:0] sd_sync, otw_sync;
   logic [2:0] line_sync;
   logic [7:0] ctrl_ff, mask_ff;
   logic [EV_BITS-1:0] status_ff, nxt_status, events, fault_now, fault_prev_ff;
   logic irq_ff;
   afrc_od_s prim_ff, sec_ff, otw_ff;
   logic wr_en, wr_ok, rd_ok;
   afrc_wreq_s wr_req;
   logic [31:0] rd_data;
   logic prim_fault, sec_fault, any_warn, report_en;
   logic sel_ctrl, sel_raw, sel_status, sel_mask, sel_cond;
   logic wsel_ctrl, wsel_status, wsel_mask;
   afrc_cond_e cond_prim, cond_sec;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Auto-recovery pulses are short, so every pin is sampled through two flops.
   afrc_sync #(.WIDTH(NUM_STAGES), .RESET_VAL(1'b1)) u_sync_sd (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(stage_shutdown_n),
      .q(sd_sync)
   );

   afrc_sync #(.WIDTH(NUM_STAGES), .RESET_VAL(1'b1)) u_sync_otw (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(stage_overtemp_n),
      .q(otw_sync)
   );

   // The shared lines are read back, since other parties may also pull them.
   afrc_sync #(.WIDTH(3), .RESET_VAL(1'b1)) u_sync_line (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({overtemp_warning_n_in, secondary_shutdown_n_in, primary_shutdown_n_in}),
      .q(line_sync)
   );

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   afrc_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_req(wr_req),
      .wr_ok(wr_ok),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   // ----------------------------------------------------------------------
   // Fault merging
   // ----------------------------------------------------------------------
   // Group membership is fixed by wiring, so it lives in a constant mask.
   assign report_en = ctrl_ff[CTRL_REPORT_EN];
   assign prim_fault = |(~sd_sync & PRIMARY_GROUP);
   assign sec_fault = |(~sd_sync & ~PRIMARY_GROUP);
   assign any_warn = |(~otw_sync);
   assign fault_now = {any_warn, sec_fault, prim_fault};

   // Lines are only pulled low or released; the driven value is always zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prim_ff <= '{out: 1'b0, oe_n: 1'b1};
         sec_ff <= '{out: 1'b0, oe_n: 1'b1};
         otw_ff <= '{out: 1'b0, oe_n: 1'b1};
      end else begin
         prim_ff.oe_n <= !(prim_fault && report_en);
         sec_ff.oe_n <= !(sec_fault && report_en);
         otw_ff.oe_n <= !(any_warn && report_en);
      end
   end

   assign primary_shutdown_n_out = prim_ff.out;
   assign primary_shutdown_n_oe_n = prim_ff.oe_n;
   assign secondary_shutdown_n_out = sec_ff.out;
   assign secondary_shutdown_n_oe_n = sec_ff.oe_n;
   assign overtemp_warning_n_out = otw_ff.out;
   assign overtemp_warning_n_oe_n = otw_ff.oe_n;

   // Mode select pins come straight from control; reset value selects recovery.
   assign mode_select_pin_a = ctrl_ff[CTRL_MODE_LSB];
   assign mode_select_pin_b = ctrl_ff[CTRL_MODE_LSB + 1];
   assign mode_select_pin_c = ctrl_ff[CTRL_MODE_LSB + 2];

   // ----------------------------------------------------------------------
   // Condition decode of the lines as seen on the wire
   // ----------------------------------------------------------------------
   // Decoding the read-back lines shows what the supervisor itself would see.
   function automatic afrc_cond_e decode(input logic warn_n, input logic sd_n);
      case ({warn_n, sd_n})
         2'h0: decode = AFRC_COND_HOT_ERROR;
         2'h1: decode = AFRC_COND_TEMP_WARN;
         2'h2: decode = AFRC_COND_UVLO_CURRENT;
         default: decode = AFRC_COND_NORMAL;
      endcase
   endfunction

   assign cond_prim = decode(line_sync[2], line_sync[0]);
   assign cond_sec = decode(line_sync[2], line_sync[1]);

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   assign sel_ctrl = (s_axi_araddr == ADDR_CTRL);
   assign sel_raw = (s_axi_araddr == ADDR_RAW);
   assign sel_status = (s_axi_araddr == ADDR_STATUS);
   assign sel_mask = (s_axi_araddr == ADDR_MASK);
   assign sel_cond = (s_axi_araddr == ADDR_COND);
   assign rd_ok = sel_ctrl || sel_raw || sel_status || sel_mask || sel_cond;
   assign wsel_ctrl = (wr_req.addr == ADDR_CTRL);
   assign wsel_status = (wr_req.addr == ADDR_STATUS);
   assign wsel_mask = (wr_req.addr == ADDR_MASK);
   assign wr_ok = wsel_ctrl || wsel_status || wsel_mask || (wr_req.addr == ADDR_RAW)
      || (wr_req.addr == ADDR_COND);

   // Read data mux; unused bits read as zero.
   always_comb begin
      rd_data = 32'h0;
      if (sel_ctrl) begin
         rd_data[7:0] = ctrl_ff;
      end else if (sel_raw) begin
         rd_data[RAW_SD_LSB +: 8] = sd_sync;
         rd_data[RAW_OTW_LSB +: 8] = otw_sync;
         rd_data[RAW_LINE_LSB +: 3] = line_sync;
      end else if (sel_status) begin
         rd_data[EV_BITS-1:0] = status_ff;
      end else if (sel_mask) begin
         rd_data[EV_BITS-1:0] = mask_ff[EV_BITS-1:0];
      end else if (sel_cond) begin
         rd_data[3:0] = {cond_sec, cond_prim};
      end
   end

   // ----------------------------------------------------------------------
   // Control and mask registers
   // ----------------------------------------------------------------------
   // Only byte lane 0 carries fields, so only its strobe matters.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= CTRL_RESET;
         mask_ff <= MASK_RESET;
      end else if (wr_en && wr_req.strb[0]) begin
         if (wsel_ctrl) begin
            ctrl_ff <= wr_req.data[7:0];
         end else if (wsel_mask) begin
            mask_ff <= {5'h0, wr_req.data[EV_BITS-1:0]};
         end
      end
   end

   // ----------------------------------------------------------------------
   // Sticky events and interrupt
   // ----------------------------------------------------------------------
   // A fault onset is an event; a new event in the clear cycle still sets.
   assign events = fault_now & ~fault_prev_ff;

   always_comb begin
      nxt_status = status_ff;
      if (wr_en && wsel_status && wr_req.strb[0]) begin
         nxt_status = status_ff & ~wr_req.data[EV_BITS-1:0];
      end
      nxt_status = nxt_status | events;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_prev_ff <= '0;
         status_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         fault_prev_ff <= fault_now;
         status_ff <= nxt_status;
         irq_ff <= |(nxt_status & mask_ff[EV_BITS-1:0]);
      end
   end

   assign irq = irq_ff;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_front_fault;
      report_en && !(sd_sync[0] && sd_sync[1] && sd_sync[6]);
   endsequence

   AST_PRIM_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
      s_front_fault |=> !primary_shutdown_n_oe_n)
      else $error("Front stage fault did not pull the primary line.");

   AST_SEC_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
      (report_en && !(&(sd_sync | PRIMARY_GROUP))) |=> !secondary_shutdown_n_oe_n)
      else $error("Back stage fault did not pull the secondary line.");

   AST_SEC_ISOLATED: assert property (@(posedge aclk) disable iff (!aresetn)
      (&(sd_sync | PRIMARY_GROUP)) |=> secondary_shutdown_n_oe_n)
      else $error("Secondary line pulled with no back stage fault.");

   AST_WARN_MERGE: assert property (@(posedge aclk) disable iff (!aresetn)
      report_en ##1 $stable(otw_sync) |-> (overtemp_warning_n_oe_n == &otw_sync))
      else $error("Warning line does not follow the stage warnings.");

   AST_NEVER_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
      !primary_shutdown_n_out && !secondary_shutdown_n_out && !overtemp_warning_n_out
      && ((primary_shutdown_n_oe_n && secondary_shutdown_n_oe_n && overtemp_warning_n_oe_n)
      || $past(report_en)))
      else $error("A report line was driven high.");

   AST_MODE_RECOVERY: assert property (@(posedge aclk)
      !aresetn |=> !(mode_select_pin_a || mode_select_pin_b || mode_select_pin_c))
      else $error("Mode pins not low after reset.");

   AST_EVENT_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
      (prim_fault && !fault_prev_ff[EV_PRIMARY]) |=> status_ff[EV_PRIMARY]
      ##1 (status_ff[EV_PRIMARY]
      || $past(wr_en && wsel_status && wr_req.strb[0] && wr_req.data[EV_PRIMARY])))
      else $error("Primary fault event was lost.");

endmodule

// ---- afrc_line_model.sv ----
// Far-side model of the three shared fault lines as the supervisor sees them.
// Assumes each line carries an outside pull-up and may be pulled by others.
`timescale 1ns/100ps
module afrc_line_model (
   input wire logic [2:0] oe_n,
   input wire logic [2:0] ext_pull,
   output logic [2:0] level
);
   // -----------------------------------------------------------------
   // Wire resolution
   // -----------------------------------------------------------------
   // A released line rises to the pull-up, and any pull wins over it.
   // This is what lets several stages share one line, so no party may
   // ever drive it high.
   assign level = oe_n & ~ext_pull;
endmodule

// ---- afrc_top_tb.sv ----
// Self-checking bench for the fault report combiner top level.
// Assumes the line model resolves the shared lines; bench is the bus master.
`timescale 1ns/100ps
module afrc_top_tb import afrc_pkg::*;;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq, mode_select_pin_a, mode_select_pin_b, mode_select_pin_c;
   logic [7:0] s_axi_awaddr, s_axi_araddr, stage_shutdown_n, stage_overtemp_n;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic primary_shutdown_n_out, primary_shutdown_n_oe_n, secondary_shutdown_n_out;
   logic secondary_shutdown_n_oe_n, overtemp_warning_n_out, overtemp_warning_n_oe_n;
   logic [2:0] ext_pull, lvl;
   wire logic primary_shutdown_n_in = lvl[0];
   wire logic secondary_shutdown_n_in = lvl[1];
   wire logic overtemp_warning_n_in = lvl[2];
   int num_errors = 0;
   int num_checks = 0;

   afrc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stage_shutdown_n,
      .stage_overtemp_n, .mode_select_pin_a, .mode_select_pin_b, .mode_select_pin_c,
      .primary_shutdown_n_in, .primary_shutdown_n_out, .primary_shutdown_n_oe_n,
      .secondary_shutdown_n_in, .secondary_shutdown_n_out, .secondary_shutdown_n_oe_n,
      .overtemp_warning_n_in, .overtemp_warning_n_out, .overtemp_warning_n_oe_n, .irq);

   afrc_line_model line_model (.oe_n({overtemp_warning_n_oe_n, secondary_shutdown_n_oe_n,
      primary_shutdown_n_oe_n}), .ext_pull(ext_pull), .level(lvl));

   // -----------------------------------------------------------------
   // Clock, compare and bus helpers
   // -----------------------------------------------------------------
   // The clock toggles every half period of 2 ns.
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Expected condition of a warning and shutdown pair.
   function automatic logic [1:0] dec(input logic w, input logic s);
      case ({w, s})
         2'b00: dec = AFRC_COND_HOT_ERROR;
         2'b01: dec = AFRC_COND_TEMP_WARN;
         2'b10: dec = AFRC_COND_UVLO_CURRENT;
         default: dec = AFRC_COND_NORMAL;
      endcase
   endfunction

   // Both helpers start just after an edge and wait on the slave's answer.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            done = 1'b1;
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            done = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
         end
      end
      @(posedge aclk);
   endtask

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      chk({mode_select_pin_c, mode_select_pin_b, mode_select_pin_a}, 0);
      rd(ADDR_CTRL, d, r);
      chk(d, 32'h08);
      rd(ADDR_MASK, d, r);
      chk(d, 32'h0);
      rd(8'h14, d, r);
      chk(r, RESP_SLVERR);
      wr(8'h14, 32'h1, r);
      chk(r, RESP_SLVERR);
      $display("test reset done");
   endtask

   // Each stage alone faults; warning comes from a different stage each time.
   task automatic t_groups();
      logic [31:0] d;
      logic [1:0] r;
      logic p;
      for (int i = 0; i < NUM_STAGES; i++) begin
         p = PRIMARY_GROUP[i];
         stage_shutdown_n <= ~(8'h01 << i);
         stage_overtemp_n <= ~(8'h80 >> i);
         // The condition read needs the line readback through its own two flops too.
         repeat (6) @(posedge aclk);
         chk(primary_shutdown_n_oe_n, !p);
         chk(secondary_shutdown_n_oe_n, p);
         chk(overtemp_warning_n_oe_n, 0);
         chk({primary_shutdown_n_out, secondary_shutdown_n_out, overtemp_warning_n_out}, 0);
         rd(ADDR_COND, d, r);
         chk(d[3:0], {dec(1'b0, p), dec(1'b0, !p)});
         stage_shutdown_n <= 8'hff;
         stage_overtemp_n <= 8'hff;
         repeat (4) @(posedge aclk);
         chk(lvl, 3'h7);
      end
      wr(ADDR_STATUS, 32'h7, r);
      $display("test groups done");
   endtask

   // One-cycle fault flashes, as auto recovery gives, must latch; only unmasked ones interrupt.
   task automatic t_irq();
      logic [31:0] d;
      logic [1:0] r;
      wr(ADDR_MASK, 32'h1, r);
      stage_shutdown_n <= 8'hfe;
      @(posedge aclk);
      stage_shutdown_n <= 8'hff;
      repeat (4) @(posedge aclk);
      chk(irq, 1);
      rd(ADDR_STATUS, d, r);
      chk(d, 32'h1);
      wr(ADDR_STATUS, 32'h1, r);
      chk(irq, 0);
      stage_shutdown_n <= 8'h7f;
      @(posedge aclk);
      stage_shutdown_n <= 8'hff;
      repeat (4) @(posedge aclk);
      chk(irq, 0);
      rd(ADDR_STATUS, d, r);
      chk(d, 32'h2);
      wr(ADDR_STATUS, 32'h7, r);
      wr(ADDR_MASK, 32'h0, r);
      $display("test irq done");
   endtask

   // Reporting off keeps lines released; mode pins follow the register.
   task automatic t_ctrl();
      logic [31:0] d;
      logic [1:0] r;
      wr(ADDR_CTRL, 32'h05, r);
      chk({mode_select_pin_c, mode_select_pin_b, mode_select_pin_a}, 3'h5);
      stage_shutdown_n <= 8'hfe;
      repeat (4) @(posedge aclk);
      chk(primary_shutdown_n_oe_n, 1);
      rd(ADDR_STATUS, d, r);
      chk(d, 32'h1);
      stage_shutdown_n <= 8'hff;
      wr(ADDR_CTRL, 32'h08, r);
      wr(ADDR_STATUS, 32'h7, r);
      chk({mode_select_pin_c, mode_select_pin_b, mode_select_pin_a}, 0);
      $display("test ctrl done");
   endtask

   // Another party pulls the shared secondary line: decode reads the wire.
   task automatic t_shared();
      logic [31:0] d;
      logic [1:0] r;
      ext_pull <= 3'b010;
      repeat (4) @(posedge aclk);
      rd(ADDR_RAW, d, r);
      chk(d[18:16], 3'h5);
      chk(d[15:0], 16'hffff);
      rd(ADDR_COND, d, r);
      chk(d[3:0], {dec(1'b1, 1'b0), dec(1'b1, 1'b1)});
      ext_pull <= 3'b000;
      $display("test shared done");
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // Main sequence and watchdog
   // -----------------------------------------------------------------
   // Inputs start idle, with every stage healthy and reset asserted.
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_pull} = '0;
      s_axi_wstrb = 4'hf;
      stage_shutdown_n = 8'hff;
      stage_overtemp_n = 8'hff;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset();
      t_groups();
      t_irq();
      t_ctrl();
      t_shared();
      end_sim();
   end

   // The tests need well under a thousand cycles; this limit is generous.
   initial begin
      #40000;
      num_errors++;
      end_sim();
   end
endmodule
